//--- rtl/cfu_pkg.sv
// Constants, opcodes, register map and carrier types of the clear-flag instruction unit
// Operation
// - Divider-zero clear instruction resets only the low four bits of its 14-bit counter.
// - Divider-one clear instruction resets only the low four bits of its 14-bit counter.
// - Reduced variant has no second divider, so its clear instruction does nothing.
// - Parameter-flag clear: immediate bit three clears the watchdog divide-by-1024 clock flag.
// - Event-mask bit zero clears the divider-zero overflow event flag.
// - Event-mask bit one clears the timer-zero underflow event flag.
// - Event-mask bit two clears the port C signal change event flag.
// - Event-mask bit four clears divider-one overflow, or pin falling edge in reduced variant.
// - Event-mask bit seven clears timer-one underflow; bits three, five, six are reserved.
// - Port-change clear instruction clears the port C signal change status flag.
// - Watchdog clear resets the low four counter bits; opcode 0x17 then 0x80.
package cfu_pkg;

  // Counter geometry
  localparam int DIV_W = 14;
  localparam int LOW_CLR_W = 4;

  // Opcodes; bits under the care mask must match
  localparam logic [15:0] OPC_DIV0 = 16'h5580;
  localparam logic [15:0] OPC_DIV1 = 16'h55C0;
  localparam logic [15:0] OPC_PRM = 16'h16D0;
  localparam logic [15:0] OPC_EVM = 16'h4000;
  localparam logic [15:0] OPC_PSR = 16'h4400;
  localparam logic [15:0] OPC_WDT = 16'h1780;
  localparam logic [15:0] CARE_ALL = 16'hFFFF;
  localparam logic [15:0] CARE_PRM = 16'hFFF0;
  localparam logic [15:0] CARE_EVM = 16'hFF00;

  // Immediate fields
  localparam int PRM_IMM_LSB = 0;
  localparam int PRM_IMM_W = 4;
  localparam int EVM_IMM_LSB = 0;
  localparam int EVM_IMM_W = 8;
  localparam logic [3:0] PRM_VALID = 4'h8;
  localparam logic [7:0] EVM_VALID = 8'h97;

  // Event and parameter flag positions
  localparam int EV_DIV0 = 0;
  localparam int EV_TMR0 = 1;
  localparam int EV_PORT = 2;
  localparam int EV_DIV1_PIN = 4;
  localparam int EV_TMR1 = 7;
  localparam int PRM_WDT1024 = 3;

  // APB register map (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_FLAGS = 8'h04;
  localparam logic [7:0] REG_PARAM = 8'h08;
  localparam logic [7:0] REG_INT_STAT = 8'h0C;
  localparam logic [7:0] REG_INT_MASK = 8'h10;

  // Field positions inside the registers
  localparam int CTRL_REDUCED = 0;
  localparam int FLG_EVM_LSB = 0;
  localparam int FLG_PSR_BIT = 8;
  localparam int FLG_PRM_LSB = 12;
  localparam int FLG_OP_LSB = 16;

  // Reset values
  localparam logic [7:0] EVM_RST = 8'h00;
  localparam logic [3:0] PRM_RST = 4'h0;
  localparam logic [7:0] MASK_RST = 8'h00;

  // Last executed clear instruction
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_DIV0 = 3'b001,
    OP_DIV1 = 3'b010,
    OP_PRM = 3'b011,
    OP_EVM = 3'b100,
    OP_PSR = 3'b101,
    OP_WDT = 3'b110,
    OP_INHIBIT = 3'b111
  } cfu_op_t;

  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } cfu_apb_req_t;

  // Event sources, each a one-cycle pulse
  typedef struct packed {
    logic div0_overflow;
    logic tmr0_underflow;
    logic port_change;
    logic div1_or_pin;
    logic tmr1_underflow;
  } cfu_events_t;

endpackage

//--- rtl/cfu_clear_unit.sv
// Clear-type instruction execution unit with its event flags and APB register slave
`timescale 1ns/100ps
`default_nettype none
module cfu_clear_unit (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [15:0] instr,
  input wire logic instr_valid,
  input wire cfu_pkg::cfu_events_t events,
  input wire cfu_pkg::cfu_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic instr_ack,
  output logic clear_divider_zero_low,
  output logic clear_divider_one_low,
  output logic clear_watchdog_low,
  output logic [7:0] event_flags,
  output logic port_change_status,
  output logic [3:0] parameter_flag,
  output logic wdt_clk_div1024,
  output logic irq
);

  // Whole state of the unit in one record
  typedef struct packed {
    logic [7:0] event_flags;
    logic port_change_status;
    logic [3:0] parameter_flag;
    logic reduced;
    logic [7:0] int_stat;
    logic [7:0] int_mask;
    logic div0_clr;
    logic div1_clr;
    logic wdt_clr;
    logic instr_ack;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    cfu_pkg::cfu_op_t last_op;
  } cfu_state_t;

  cfu_state_t state_q;
  cfu_state_t state_d;

  // Opcode compare under a care mask
  function automatic logic op_match(input logic [15:0] op, input logic [15:0] pat, input logic [15:0] care);
    op_match = ((op ^ pat) & care) == 16'h0000;
  endfunction

  // Map an instruction word to the clear operation it names
  function automatic cfu_pkg::cfu_op_t op_decode(input logic [15:0] op, input logic reduced);
    cfu_pkg::cfu_op_t kind;
    kind = cfu_pkg::OP_NONE;
    if (op_match(op, cfu_pkg::OPC_DIV0, cfu_pkg::CARE_ALL)) begin
      kind = cfu_pkg::OP_DIV0;
    end else if (op_match(op, cfu_pkg::OPC_DIV1, cfu_pkg::CARE_ALL)) begin
      kind = reduced ? cfu_pkg::OP_INHIBIT : cfu_pkg::OP_DIV1;
    end else if (op_match(op, cfu_pkg::OPC_PRM, cfu_pkg::CARE_PRM)) begin
      kind = cfu_pkg::OP_PRM;
    end else if (op_match(op, cfu_pkg::OPC_EVM, cfu_pkg::CARE_EVM)) begin
      kind = cfu_pkg::OP_EVM;
    end else if (op_match(op, cfu_pkg::OPC_PSR, cfu_pkg::CARE_ALL)) begin
      kind = cfu_pkg::OP_PSR;
    end else if (op_match(op, cfu_pkg::OPC_WDT, cfu_pkg::CARE_ALL)) begin
      kind = cfu_pkg::OP_WDT;
    end
    op_decode = kind;
  endfunction

  // Is this byte address one of ours
  function automatic logic addr_mapped(input logic [7:0] addr);
    addr_mapped = (addr == cfu_pkg::REG_CTRL) || (addr == cfu_pkg::REG_FLAGS) ||
                  (addr == cfu_pkg::REG_PARAM) || (addr == cfu_pkg::REG_INT_STAT) ||
                  (addr == cfu_pkg::REG_INT_MASK);
  endfunction

  // Next-state logic
  always_comb begin
    cfu_pkg::cfu_op_t kind;
    logic [7:0] ev_set;
    logic [7:0] ev_clr;
    logic [3:0] prm_clr;
    logic [7:0] evm_imm;
    logic [3:0] prm_imm;
    logic psr_set;
    logic psr_clr;
    logic [7:0] stat_w1c;
    logic apb_setup_done;
    logic apb_commit;
    logic [31:0] rdata;

    kind = cfu_pkg::OP_NONE;
    ev_set = 8'h00;
    ev_clr = 8'h00;
    prm_clr = 4'h0;
    evm_imm = 8'h00;
    prm_imm = 4'h0;
    psr_set = 1'b0;
    psr_clr = 1'b0;
    stat_w1c = 8'h00;
    apb_setup_done = 1'b0;
    apb_commit = 1'b0;
    rdata = 32'h0000_0000;
    state_d = state_q;

    // Strobes last one machine cycle only
    state_d.div0_clr = 1'b0;
    state_d.div1_clr = 1'b0;
    state_d.wdt_clr = 1'b0;
    state_d.instr_ack = 1'b0;

    // Incoming hardware events
    ev_set[cfu_pkg::EV_DIV0] = events.div0_overflow;
    ev_set[cfu_pkg::EV_TMR0] = events.tmr0_underflow;
    ev_set[cfu_pkg::EV_PORT] = events.port_change;
    ev_set[cfu_pkg::EV_DIV1_PIN] = events.div1_or_pin;
    ev_set[cfu_pkg::EV_TMR1] = events.tmr1_underflow;
    psr_set = events.port_change;

    // Execute one instruction per valid cycle
    if (instr_valid) begin
      kind = op_decode(instr, state_q.reduced);
      evm_imm = instr[cfu_pkg::EVM_IMM_LSB +: cfu_pkg::EVM_IMM_W];
      prm_imm = instr[cfu_pkg::PRM_IMM_LSB +: cfu_pkg::PRM_IMM_W];
      state_d.instr_ack = 1'b1;
      case (kind)
        cfu_pkg::OP_DIV0: begin
          state_d.div0_clr = 1'b1;
        end
        cfu_pkg::OP_DIV1: begin
          state_d.div1_clr = 1'b1;
        end
        cfu_pkg::OP_INHIBIT: begin
          state_d.div1_clr = 1'b0;
        end
        cfu_pkg::OP_PRM: begin
          prm_clr = prm_imm & cfu_pkg::PRM_VALID;
        end
        cfu_pkg::OP_EVM: begin
          // Reserved positions are ignored, zero bits leave flags as they are
          ev_clr = evm_imm & cfu_pkg::EVM_VALID;
        end
        cfu_pkg::OP_PSR: begin
          psr_clr = 1'b1;
        end
        cfu_pkg::OP_WDT: begin
          state_d.wdt_clr = 1'b1;
        end
        default: begin
          state_d.instr_ack = 1'b1;
        end
      endcase
      if (kind != cfu_pkg::OP_NONE) begin
        state_d.last_op = kind;
      end
    end

    // A flag set in the same cycle as its clear stays set
    state_d.event_flags = ((state_q.event_flags & ~ev_clr) | ev_set) & cfu_pkg::EVM_VALID;
    state_d.port_change_status = (state_q.port_change_status & ~psr_clr) | psr_set;
    state_d.parameter_flag = state_q.parameter_flag & ~prm_clr;

    // APB: first access cycle prepares the answer, second completes it
    apb_setup_done = apb_req.psel && apb_req.penable && !state_q.pready;
    apb_commit = apb_req.psel && apb_req.penable && state_q.pready;
    state_d.pready = apb_setup_done;
    if (apb_setup_done) begin
      case (apb_req.paddr)
        cfu_pkg::REG_CTRL: begin
          rdata[cfu_pkg::CTRL_REDUCED] = state_q.reduced;
        end
        cfu_pkg::REG_FLAGS: begin
          rdata[cfu_pkg::FLG_EVM_LSB +: cfu_pkg::EVM_IMM_W] = state_q.event_flags;
          rdata[cfu_pkg::FLG_PSR_BIT] = state_q.port_change_status;
          rdata[cfu_pkg::FLG_PRM_LSB +: cfu_pkg::PRM_IMM_W] = state_q.parameter_flag;
          rdata[cfu_pkg::FLG_OP_LSB +: 3] = state_q.last_op;
        end
        cfu_pkg::REG_PARAM: begin
          rdata[3:0] = state_q.parameter_flag;
        end
        cfu_pkg::REG_INT_STAT: begin
          rdata[7:0] = state_q.int_stat;
        end
        cfu_pkg::REG_INT_MASK: begin
          rdata[7:0] = state_q.int_mask;
        end
        default: begin
          rdata = 32'h0000_0000;
        end
      endcase
      state_d.prdata = apb_req.pwrite ? 32'h0000_0000 : rdata;
      state_d.pslverr = !addr_mapped(apb_req.paddr);
    end else if (apb_commit) begin
      state_d.prdata = 32'h0000_0000;
      state_d.pslverr = 1'b0;
    end

    // Register writes take effect at the completing edge only
    if (apb_commit && apb_req.pwrite) begin
      case (apb_req.paddr)
        cfu_pkg::REG_CTRL: begin
          state_d.reduced = apb_req.pwdata[cfu_pkg::CTRL_REDUCED];
        end
        cfu_pkg::REG_PARAM: begin
          // Software write arms the flag; an instruction clear in the same cycle loses
          state_d.parameter_flag = apb_req.pwdata[cfu_pkg::PRM_IMM_LSB +: cfu_pkg::PRM_IMM_W] & cfu_pkg::PRM_VALID;
        end
        cfu_pkg::REG_INT_STAT: begin
          stat_w1c = apb_req.pwdata[7:0];
        end
        cfu_pkg::REG_INT_MASK: begin
          state_d.int_mask = apb_req.pwdata[cfu_pkg::EVM_IMM_LSB +: cfu_pkg::EVM_IMM_W] & cfu_pkg::EVM_VALID;
        end
        default: begin
          stat_w1c = 8'h00;
        end
      endcase
    end

    // Sticky interrupt status, set beats write-one-to-clear
    state_d.int_stat = ((state_q.int_stat & ~stat_w1c) | ev_set) & cfu_pkg::EVM_VALID;
    state_d.irq = |(state_d.int_stat & state_d.int_mask);
  end

  // State register; clock enable freezes everything
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= '{
        event_flags: cfu_pkg::EVM_RST,
        port_change_status: 1'b0,
        parameter_flag: cfu_pkg::PRM_RST,
        reduced: 1'b0,
        int_stat: cfu_pkg::EVM_RST,
        int_mask: cfu_pkg::MASK_RST,
        div0_clr: 1'b0,
        div1_clr: 1'b0,
        wdt_clr: 1'b0,
        instr_ack: 1'b0,
        irq: 1'b0,
        pready: 1'b0,
        pslverr: 1'b0,
        prdata: 32'h0000_0000,
        last_op: cfu_pkg::OP_NONE
      };
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // Outputs straight from the state register
  assign prdata = state_q.prdata;
  assign pready = state_q.pready;
  assign pslverr = state_q.pslverr;
  assign instr_ack = state_q.instr_ack;
  assign clear_divider_zero_low = state_q.div0_clr;
  assign clear_divider_one_low = state_q.div1_clr;
  assign clear_watchdog_low = state_q.wdt_clr;
  assign event_flags = state_q.event_flags;
  assign port_change_status = state_q.port_change_status;
  assign parameter_flag = state_q.parameter_flag;
  assign wdt_clk_div1024 = state_q.parameter_flag[cfu_pkg::PRM_WDT1024];
  assign irq = state_q.irq;

endmodule // cfu_clear_unit
`default_nettype wire

//--- test/cfu_clear_unit_checker.sv
// Port-level assertion checker for the clear-flag instruction unit
`timescale 1ns/100ps
`default_nettype none
module cfu_clear_unit_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [15:0] instr,
  input wire logic instr_valid,
  input wire cfu_pkg::cfu_events_t events,
  input wire cfu_pkg::cfu_apb_req_t apb_req,
  input wire logic pready,
  input wire logic instr_ack,
  input wire logic clear_divider_zero_low,
  input wire logic clear_watchdog_low,
  input wire logic [7:0] event_flags,
  input wire logic port_change_status,
  input wire logic [3:0] parameter_flag,
  input wire logic wdt_clk_div1024
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic evm_go;
  // Event-mask clear taken at this edge
  assign evm_go = ce && instr_valid && instr[15:8] == 8'h40;
  // Instruction word taken at this edge
  sequence s_take(logic [15:0] op);
    ce && instr_valid && instr == op;
  endsequence
  // Setup cycle followed by the first access cycle
  sequence s_setup;
    ce && apb_req.psel && !apb_req.penable ##1 apb_req.psel && apb_req.penable;
  endsequence
  a_div0_strobe: assert property (s_take(cfu_pkg::OPC_DIV0) |=> clear_divider_zero_low)
    else $error("divider zero clear strobe missing");
  a_wdt_strobe: assert property (s_take(cfu_pkg::OPC_WDT) |=> clear_watchdog_low && !clear_divider_zero_low)
    else $error("watchdog clear strobe wrong");
  a_psr_clear: assert property (s_take(cfu_pkg::OPC_PSR) ##0 !events.port_change |=> !port_change_status)
    else $error("port change status not cleared");
  a_div0_event: assert property (evm_go && instr[0] && !events.div0_overflow |=> !event_flags[0])
    else $error("divider zero event not cleared");
  a_tmr1_event: assert property (evm_go && instr[7] && !events.tmr1_underflow |=> !event_flags[7])
    else $error("timer one event not cleared");
  a_mask_keeps: assert property (evm_go && !instr[1] && event_flags[1] |=> event_flags[1])
    else $error("unmasked event flag lost");
  a_ack_pulse: assert property (ce && instr_valid |=> instr_ack)
    else $error("instruction not acknowledged next cycle");
  a_wdt_clock: assert property (wdt_clk_div1024 == parameter_flag[3] && parameter_flag[2:0] == 3'h0)
    else $error("parameter flag and watchdog clock disagree");
  a_reserved_zero: assert property (event_flags[6:5] == 2'h0 && !event_flags[3])
    else $error("reserved event flag set");
  a_apb_answer: assert property (s_setup |=> pready)
    else $error("register access not answered in time");
endmodule // cfu_clear_unit_checker
bind cfu_clear_unit cfu_clear_unit_checker u_chk (.clk(clk), .sys_rst(sys_rst), .ce(ce), .instr(instr),
  .instr_valid(instr_valid), .events(events), .apb_req(apb_req), .pready(pready), .instr_ack(instr_ack),
  .clear_divider_zero_low(clear_divider_zero_low), .clear_watchdog_low(clear_watchdog_low),
  .event_flags(event_flags), .port_change_status(port_change_status), .parameter_flag(parameter_flag),
  .wdt_clk_div1024(wdt_clk_div1024));
`default_nettype wire

//--- test/clear_flag_instruction_unit_test.sv
// Self-checking testbench for the clear-flag instruction unit
`timescale 1ns/100ps
`default_nettype none
module clear_flag_instruction_unit_test;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] instr = 16'h0000;
  logic instr_valid = 1'b0;
  cfu_pkg::cfu_events_t events = '0;
  cfu_pkg::cfu_apb_req_t apb_req = '0;
  logic [31:0] prdata, rd;
  logic ce = 1'b1;
  logic [7:0] ev_flags;
  logic [3:0] prm_flags;
  logic pready, pslverr, ack, clr0, clr1, clrw, pcs, wdt, irq, err;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  // Clock enable is driven so that freezing can be checked at the end
  cfu_clear_unit u_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .instr(instr), .instr_valid(instr_valid),
    .events(events), .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr), .instr_ack(ack),
    .clear_divider_zero_low(clr0), .clear_divider_one_low(clr1), .clear_watchdog_low(clrw),
    .event_flags(ev_flags), .port_change_status(pcs), .parameter_flag(prm_flags), .wdt_clk_div1024(wdt),
    .irq(irq));
  // 100 ns period
  always #50 clk = ~clk;
  // Hang guard, far above the roughly one hundred cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      errors = errors + 1;
      wrap_up();
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  // Only the bench's cycle ceiling ends the wait for pready
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    @(posedge clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    apb_req <= '0;
    repeat (2) @(negedge clk);
  endtask
  // One instruction; strobes as {ack, div0, div1, wdt} in the following cycle
  task automatic exec(input logic [15:0] w, input logic [3:0] strb);
    @(posedge clk);
    instr <= w;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
    @(negedge clk);
    chk("strobes", {28'h0, strb}, {28'h0, ack, clr0, clr1, clrw});
  endtask
  // One-cycle event pulse
  task automatic ev(input logic [4:0] v);
    @(posedge clk);
    events <= v;
    @(posedge clk);
    events <= '0;
    @(negedge clk);
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    apb(1'b0, cfu_pkg::REG_FLAGS, 32'h0);
    chk("flags_rst", 32'h0, rd);
    chk("mapped_ok", 32'h0, {31'h0, err});
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    ev(5'h1F);
    chk("flags_set", 32'h97, {24'h0, ev_flags});
    exec(16'h4091, 4'h8);
    chk("flags_clr", 32'h06, {24'h0, ev_flags});
    exec(16'h4006, 4'h8);
    chk("flags_clr2", 32'h0, {24'h0, ev_flags});
    chk("psr_kept", 32'h1, {31'h0, pcs});
    exec(cfu_pkg::OPC_PSR, 4'h8);
    chk("psr_clr", 32'h0, {31'h0, pcs});
    exec(cfu_pkg::OPC_DIV0, 4'hC);
    exec(cfu_pkg::OPC_DIV1, 4'hA);
    exec(cfu_pkg::OPC_WDT, 4'h9);
    exec(16'h1781, 4'h8);
    chk("no_ovf", 32'h0, {24'h0, ev_flags});
    apb(1'b1, cfu_pkg::REG_CTRL, 32'h1);
    exec(cfu_pkg::OPC_DIV1, 4'h8);
    apb(1'b0, cfu_pkg::REG_FLAGS, 32'h0);
    chk("last_op", 32'h7, {29'h0, rd[18:16]});
    apb(1'b1, cfu_pkg::REG_CTRL, 32'h0);
    apb(1'b1, cfu_pkg::REG_PARAM, 32'hF);
    chk("param_set", 32'h18, {27'h0, wdt, prm_flags});
    exec(16'h16D7, 4'h8);
    chk("param_keep", 32'h18, {27'h0, wdt, prm_flags});
    exec(16'h16D8, 4'h8);
    chk("param_clr", 32'h0, {27'h0, wdt, prm_flags});
    // Interrupt: mask, raise, mask off, clear by writing ones
    apb(1'b1, cfu_pkg::REG_INT_MASK, 32'hFF);
    apb(1'b0, cfu_pkg::REG_INT_MASK, 32'h0);
    chk("mask_rd", 32'h97, rd);
    chk("irq_on", 32'h1, {31'h0, irq});
    apb(1'b1, cfu_pkg::REG_INT_MASK, 32'h0);
    chk("irq_masked", 32'h0, {31'h0, irq});
    ev(5'h10);
    apb(1'b0, cfu_pkg::REG_INT_STAT, 32'h0);
    chk("stat_rd", 32'h97, rd);
    apb(1'b1, cfu_pkg::REG_INT_MASK, 32'h1);
    chk("irq_div0", 32'h1, {31'h0, irq});
    apb(1'b1, cfu_pkg::REG_INT_STAT, 32'hFF);
    chk("irq_clr", 32'h0, {31'h0, irq});
    apb(1'b0, cfu_pkg::REG_INT_STAT, 32'h0);
    chk("stat_clr", 32'h0, rd);
    // Clock enable low: a timer-zero event must not reach the flags
    @(posedge clk);
    ce <= 1'b0;
    ev(5'h08);
    chk("ce_freeze", 32'h01, {24'h0, ev_flags});
    @(posedge clk);
    ce <= 1'b1;
    // A port change in the cycle of its clear wins over the clear
    @(posedge clk);
    events <= 5'h04;
    instr <= cfu_pkg::OPC_PSR;
    instr_valid <= 1'b1;
    @(posedge clk);
    events <= '0;
    instr_valid <= 1'b0;
    @(negedge clk);
    chk("psr_set_wins", 32'h1, {31'h0, pcs});
    wrap_up();
  end
endmodule // clear_flag_instruction_unit_test
`default_nettype wire
